// ==== rtl/fsr_link.sv ====
/*
  Serial-clock side of the status bank: captures the opcode and up to
  four following bytes, shifts status bytes out on falling edges.
  Assumes its record is read only while chip select is high and that
  status_image is frozen while chip select is low.
*/
module fsr_link
  import fsr_pkg::*;
(
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic link_rst,
  // Status image from the system side
  input wire logic [23:0] status_image,
  // Serial data out
  output logic so_out,
  output logic so_oe,
  // Frame record
  output logic frame_seq,
  output logic [2:0] frame_bits,
  output logic [2:0] frame_bytes,
  output logic [7:0] frame_slot [LINK_SLOTS]
);

  logic armed_reg;
  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  logic [7:0] out_byte;

  // Armed while deselected so each frame starts from bit zero
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      armed_reg <= 1'b1;
    else
      armed_reg <= 1'b0;
  end

  assign cur_bit = armed_reg ? 3'h0 : frame_bits;
  assign cur_byte = armed_reg ? 3'h0 : frame_bytes;

  // Bit and byte counting; sequence toggles once per frame
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      frame_seq <= 1'b0;
      frame_bits <= 3'h0;
      frame_bytes <= 3'h0;
    end
    else
    begin
      if (armed_reg)
        frame_seq <= ~frame_seq;
      frame_bits <= cur_bit + 3'h1;
      if (cur_bit == 3'h7 && cur_byte != BYTE_SAT)
        frame_bytes <= cur_byte + 3'h1;
      else
        frame_bytes <= cur_byte;
    end
  end

  // Byte slots, most significant bit first
  always_ff @(posedge sclk)
  begin
    if (cur_byte < 3'(LINK_SLOTS))
      frame_slot[cur_byte][3'h7 - cur_bit] <= si;
  end

  // Register selected by the read opcode; repeats while clocked
  always_comb
  begin
    case (frame_slot[0])
      OP_RD_SR1: out_byte = status_image[7:0];
      OP_RD_SR2: out_byte = status_image[15:8];
      OP_RD_SR3: out_byte = status_image[23:16];
      default: out_byte = 8'h00;
    endcase
  end

  // Shift out on falling edges once the opcode byte is complete
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_oe <= 1'b0;
      so_out <= 1'b0;
    end
    else if (!armed_reg && frame_bytes != 3'h0 && out_byte_valid(frame_slot[0]))
    begin
      so_oe <= 1'b1;
      so_out <= out_byte[3'h7 - frame_bits];
    end
    else
    begin
      so_oe <= 1'b0;
      so_out <= 1'b0;
    end
  end

  function automatic logic out_byte_valid(input logic [7:0] op);
    out_byte_valid = (op == OP_RD_SR1) || (op == OP_RD_SR2) || (op == OP_RD_SR3);
  endfunction : out_byte_valid

endmodule : fsr_link

// ==== rtl/fsr_pkg.sv ====
/*
  Constants shared by the flash status register bank: opcodes, bit
  positions, write masks, frame lengths, states and timing.
  Assumes a 100 MHz system clock.
*/
package fsr_pkg;

  // Timing; the status write time is a plain default
  localparam int SYS_CLK_MHZ = 100;
  localparam int STATUS_WRITE_NS = 1000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * SYS_CLK_MHZ + 999) / 1000;

  // Serial opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_RD_SR3 = 8'h15;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_PAGE_PGM = 8'h02;
  localparam logic [7:0] OP_PAGE_PGM4 = 8'h12;
  localparam logic [7:0] OP_QUAD_PGM = 8'h32;
  localparam logic [7:0] OP_QUAD_PGM4 = 8'h34;
  localparam logic [7:0] OP_SECT_WIPE = 8'h20;
  localparam logic [7:0] OP_SECT_WIPE4 = 8'h21;
  localparam logic [7:0] OP_BLK32_WIPE = 8'h52;
  localparam logic [7:0] OP_BLK32_WIPE4 = 8'h5c;
  localparam logic [7:0] OP_BLK64_WIPE = 8'hd8;
  localparam logic [7:0] OP_BLK64_WIPE4 = 8'hdc;
  localparam logic [7:0] OP_CHIP_WIPE = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_ALT = 8'hc7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_CLR_FLAGS = 8'h30;
  localparam logic [7:0] OP_ENTER_4B = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B = 8'he9;

  // Bit positions in the 24-bit status image
  localparam int B_BUSY = 0;
  localparam int B_WEL = 1;
  localparam int B_BP_LO = 2;
  localparam int B_TB = 6;
  localparam int B_GUARD_LO = 7;
  localparam int B_ADS = 8;
  localparam int B_QE = 9;
  localparam int B_PGM_PAUSE = 10;
  localparam int B_LOCK_LO = 11;
  localparam int B_GUARD_HI = 14;
  localparam int B_ERS_PAUSE = 15;
  localparam int B_PGM_ERR = 18;
  localparam int B_ERS_ERR = 19;
  localparam int B_ADP = 20;
  localparam int B_DRV_LO = 21;

  // Write masks: writable non-volatile bits, set-only bits, byte lanes
  localparam logic [23:0] NV_WRITE_MASK = 24'h7078fc;
  localparam logic [23:0] OTP_MASK = 24'h003840;
  localparam logic [23:0] MASK_LOW = 24'h0000ff;
  localparam logic [23:0] MASK_LOW_MID = 24'h00ffff;
  localparam logic [23:0] MASK_MID = 24'h00ff00;
  localparam logic [23:0] MASK_HIGH = 24'hff0000;

  // Frame lengths in whole bytes, opcode included
  localparam int LINK_SLOTS = 5;
  localparam logic [2:0] BYTE_SAT = 3'h7;
  localparam logic [2:0] LEN_DATA1 = 3'h2;
  localparam logic [2:0] LEN_DATA2 = 3'h3;
  localparam logic [2:0] LEN_ADDR3 = 3'h4;
  localparam logic [2:0] LEN_ADDR4 = 3'h5;
  localparam logic [2:0] LEN_PGM4 = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_ARRAY = 2'b10,
    ST_STATUS = 2'b11
  } fsr_state_e;

endpackage : fsr_pkg

// ==== rtl/fsr_status_bank.sv ====
/*
  Flash status register bank: three 8-bit status registers, serial
  command decode for the status commands, and the gate in front of the
  array program and erase engine.
  Assumes an array engine on sys_clk, an external protect-area decoder
  answering target_protected within one cycle of op_addr, and a
  non-volatile store presenting nv_image during reset.
*/
module fsr_status_bank
  import fsr_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Non-volatile store
  input wire logic [23:0] nv_image,
  output logic [23:0] nv_bits,
  output logic nv_store,
  // Extended address register
  input wire logic [7:0] ext_addr_hi,
  // Array engine
  output logic op_start,
  output logic [7:0] op_code,
  output logic [31:0] op_addr,
  output logic suspend_req,
  output logic resume_req,
  input wire logic engine_done,
  input wire logic engine_fail,
  input wire logic otp_prog_hit,
  input wire logic otp_erase_hit,
  // Protect decoder
  output logic [3:0] block_protect,
  output logic top_bottom,
  input wire logic target_protected,
  // Pad and mode control
  output logic [1:0] drive_strength,
  output logic quad_enable,
  output logic [2:0] security_lock,
  output logic addr_4byte
);

  fsr_state_e state_reg;
  logic [23:0] nv_reg;
  logic [7:0] timer_reg;
  logic wel_reg;
  logic ers_pause_reg;
  logic pgm_pause_reg;
  logic pgm_err_reg;
  logic ers_err_reg;
  logic pend_pgm_reg;
  logic pend_chip_reg;
  logic rst_armed_reg;
  logic seq_seen_reg;
  logic cs_prev_reg;
  logic link_rst_reg;
  logic [23:0] snap_reg;
  logic [23:0] status_now;
  logic cs_sync;
  logic frame_seq;
  logic [2:0] frame_bits;
  logic [2:0] frame_bytes;
  logic [7:0] frame_slot [LINK_SLOTS];
  logic frame_end;
  logic idle;
  logic paused;
  logic wr_ok;
  logic prot_hit;
  logic status_done;
  logic array_done;
  // Decode results
  logic wel_set;
  logic wel_clr;
  logic wr_go;
  logic [23:0] wr_data;
  logic [23:0] wr_mask;
  logic [23:0] wr_keep;
  logic arr_go;
  logic arr_pgm;
  logic arr_chip;
  logic arr_alen4;
  logic [2:0] arr_need;
  logic [31:0] arr_addr;
  logic pause_go;
  logic resume_go;
  logic rst_en_go;
  logic rst_go;
  logic clr_go;
  logic ads_on;
  logic ads_off;

  // Serial clock domain
  fsr_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .link_rst(link_rst_reg),
    .status_image(snap_reg),
    .so_out(so_out),
    .so_oe(so_oe),
    .frame_seq(frame_seq),
    .frame_bits(frame_bits),
    .frame_bytes(frame_bytes),
    .frame_slot(frame_slot)
  );

  // Chip select into the system domain
  fsr_sync2 #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(cs_n),
    .q(cs_sync)
  );

  assign idle = (state_reg == ST_IDLE);
  assign paused = ers_pause_reg | pgm_pause_reg;
  // A new sequence value guards against empty chip-select pulses
  assign frame_end = cs_sync & ~cs_prev_reg & (frame_seq != seq_seen_reg);
  assign wr_ok = wel_reg & ~nv_reg[B_GUARD_HI];
  assign prot_hit = (state_reg == ST_CHECK) & target_protected & ~pend_chip_reg;
  assign status_done = (state_reg == ST_STATUS) && (timer_reg == 8'h00);
  assign array_done = (state_reg == ST_ARRAY) & engine_done;

  // Frame decode; the link record is stable while deselected
  always_comb
  begin
    wel_set = 1'b0;
    wel_clr = 1'b0;
    wr_go = 1'b0;
    wr_data = 24'h000000;
    wr_mask = 24'h000000;
    arr_go = 1'b0;
    arr_pgm = 1'b0;
    arr_chip = 1'b0;
    arr_alen4 = 1'b0;
    pause_go = 1'b0;
    resume_go = 1'b0;
    rst_en_go = 1'b0;
    rst_go = 1'b0;
    clr_go = 1'b0;
    ads_on = 1'b0;
    ads_off = 1'b0;
    case (frame_slot[0])
      OP_PAGE_PGM4, OP_QUAD_PGM4, OP_SECT_WIPE4, OP_BLK32_WIPE4, OP_BLK64_WIPE4:
        arr_alen4 = 1'b1;
      default:
        arr_alen4 = addr_4byte;
    endcase
    case (frame_slot[0])
      OP_PAGE_PGM, OP_PAGE_PGM4, OP_QUAD_PGM, OP_QUAD_PGM4:
        arr_pgm = 1'b1;
      default:
        arr_pgm = 1'b0;
    endcase
    if (arr_pgm)
      arr_need = arr_alen4 ? LEN_PGM4 : LEN_ADDR4;
    else
      arr_need = arr_alen4 ? LEN_ADDR4 : LEN_ADDR3;
    if (arr_alen4)
      arr_addr = {frame_slot[1], frame_slot[2], frame_slot[3], frame_slot[4]};
    else
      arr_addr = {ext_addr_hi, frame_slot[1], frame_slot[2], frame_slot[3]};
    // Writing commands must end on a byte boundary
    if (frame_end && frame_bits == 3'h0)
    begin
      case (frame_slot[0])
        OP_WRITE_UNLOCK: wel_set = idle;
        OP_WRITE_LOCK: wel_clr = idle;
        OP_WR_SR1:
        begin
          wr_go = idle && frame_bytes >= LEN_DATA1;
          wr_data = {8'h00, frame_slot[2], frame_slot[1]};
          wr_mask = (frame_bytes >= LEN_DATA2) ? MASK_LOW_MID : MASK_LOW;
        end
        OP_WR_SR2:
        begin
          wr_go = idle && frame_bytes >= LEN_DATA1;
          wr_data = {8'h00, frame_slot[1], 8'h00};
          wr_mask = MASK_MID;
        end
        OP_WR_SR3:
        begin
          wr_go = idle && frame_bytes >= LEN_DATA1;
          wr_data = {frame_slot[1], 16'h0000};
          wr_mask = MASK_HIGH;
        end
        OP_PAGE_PGM, OP_PAGE_PGM4, OP_QUAD_PGM, OP_QUAD_PGM4, OP_SECT_WIPE,
        OP_SECT_WIPE4, OP_BLK32_WIPE, OP_BLK32_WIPE4, OP_BLK64_WIPE, OP_BLK64_WIPE4:
          arr_go = idle && !paused && frame_bytes >= arr_need;
        OP_CHIP_WIPE, OP_CHIP_WIPE_ALT:
        begin
          arr_chip = 1'b1;
          arr_go = idle && !paused && block_protect == 4'h0;
        end
        OP_SUSPEND: pause_go = 1'b1;
        OP_RESUME: resume_go = paused;
        OP_RST_ENABLE: rst_en_go = 1'b1;
        OP_RST: rst_go = rst_armed_reg;
        OP_CLR_FLAGS: clr_go = 1'b1;
        OP_ENTER_4B: ads_on = idle;
        OP_EXIT_4B: ads_off = idle;
        default: wel_set = 1'b0;
      endcase
    end
  end

  assign wr_keep = (nv_reg & ~(wr_mask & NV_WRITE_MASK)) | (wr_data & wr_mask & NV_WRITE_MASK)
                   | (nv_reg & OTP_MASK);

  // Non-volatile image; a power cycle drops the temporary lock-down
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      nv_reg <= nv_image & NV_WRITE_MASK;
      if (nv_image[B_GUARD_HI] && !nv_image[B_GUARD_LO])
        nv_reg[B_GUARD_HI] <= 1'b0;
      nv_store <= 1'b0;
    end
    else
    begin
      nv_store <= 1'b0;
      if (idle && wr_go && wr_ok)
      begin
        nv_reg <= wr_keep;
        nv_store <= 1'b1;
      end
    end
  end

  // Write enable latch
  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_go)
      wel_reg <= 1'b0;
    else if (wel_clr || status_done || array_done)
      wel_reg <= 1'b0;
    else if (wel_set)
      wel_reg <= 1'b1;
  end

  // Current address mode, caught from the strap image at init
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      addr_4byte <= nv_image[B_ADP];
    else if (rst_go)
      addr_4byte <= nv_reg[B_ADP];
    else if (ads_on)
      addr_4byte <= 1'b1;
    else if (ads_off)
      addr_4byte <= 1'b0;
  end

  // Suspend flags
  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_go || (idle && resume_go))
    begin
      ers_pause_reg <= 1'b0;
      pgm_pause_reg <= 1'b0;
    end
    else if (state_reg == ST_ARRAY && pause_go && !engine_done)
    begin
      ers_pause_reg <= ~pend_pgm_reg;
      pgm_pause_reg <= pend_pgm_reg;
    end
  end

  // Error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pgm_err_reg <= 1'b0;
      ers_err_reg <= 1'b0;
    end
    else
    begin
      pgm_err_reg <= (pgm_err_reg & ~clr_go) | (prot_hit & pend_pgm_reg)
                     | (engine_fail & pend_pgm_reg) | otp_prog_hit;
      ers_err_reg <= (ers_err_reg & ~clr_go) | (prot_hit & ~pend_pgm_reg)
                     | (engine_fail & ~pend_pgm_reg) | otp_erase_hit;
    end
  end

  // Operation sequencer
  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_go)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 8'h00;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 32'h00000000;
      suspend_req <= 1'b0;
      resume_req <= 1'b0;
      pend_pgm_reg <= 1'b0;
      pend_chip_reg <= 1'b0;
    end
    else
    begin
      op_start <= 1'b0;
      suspend_req <= 1'b0;
      resume_req <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (wr_go && wr_ok)
          begin
            state_reg <= ST_STATUS;
            timer_reg <= 8'(STATUS_WRITE_CYC - 1);
          end
          else if (arr_go && wel_reg)
          begin
            state_reg <= ST_CHECK;
            op_code <= frame_slot[0];
            op_addr <= arr_addr;
            pend_pgm_reg <= arr_pgm;
            pend_chip_reg <= arr_chip;
          end
          else if (resume_go)
          begin
            state_reg <= ST_ARRAY;
            resume_req <= 1'b1;
          end
        end
        ST_CHECK:
        begin
          if (prot_hit)
            state_reg <= ST_IDLE;
          else
          begin
            op_start <= 1'b1;
            state_reg <= ST_ARRAY;
          end
        end
        ST_ARRAY:
        begin
          if (engine_done)
            state_reg <= ST_IDLE;
          else if (pause_go)
          begin
            suspend_req <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_STATUS:
        begin
          if (timer_reg == 8'h00)
            state_reg <= ST_IDLE;
          else
            timer_reg <= timer_reg - 8'h01;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Frame tracking and software reset pairing
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cs_prev_reg <= 1'b1;
      seq_seen_reg <= 1'b0;
      rst_armed_reg <= 1'b0;
      link_rst_reg <= 1'b1;
    end
    else
    begin
      cs_prev_reg <= cs_sync;
      link_rst_reg <= 1'b0;
      if (frame_end)
      begin
        seq_seen_reg <= frame_seq;
        rst_armed_reg <= rst_en_go;
      end
    end
  end

  // Live status word with volatile bits overlaid
  always_comb
  begin
    status_now = nv_reg & NV_WRITE_MASK;
    status_now[B_BUSY] = ~idle;
    status_now[B_WEL] = wel_reg;
    status_now[B_ADS] = addr_4byte;
    status_now[B_QE] = 1'b1;
    status_now[B_PGM_PAUSE] = pgm_pause_reg;
    status_now[B_ERS_PAUSE] = ers_pause_reg;
    status_now[B_PGM_ERR] = pgm_err_reg;
    status_now[B_ERS_ERR] = ers_err_reg;
  end

  // Snapshot frozen while selected, so the link reads a stable word
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      snap_reg <= 24'h000000;
    else if (cs_sync)
      snap_reg <= status_now;
  end

  // Quad enable held high from reset on
  always_ff @(posedge sys_clk)
  begin
    quad_enable <= 1'b1;
  end

  // Control fields straight from the non-volatile image
  assign nv_bits = nv_reg;
  assign block_protect = nv_reg[B_BP_LO +: 4];
  assign top_bottom = nv_reg[B_TB];
  assign drive_strength = nv_reg[B_DRV_LO +: 2];
  assign security_lock = nv_reg[B_LOCK_LO +: 3];

endmodule : fsr_status_bank

// ==== rtl/fsr_sync2.sv ====
/*
  Two-flop level synchroniser.
  Assumes d is a level from another clock domain or a pin.
*/
module fsr_sync2
  import fsr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : fsr_sync2

// ==== sim/fsr_host_model.sv ====
/*
  Host serial controller model: mode 0 frames, MSB first, 80 ns clock.
  Assumes the bench calls frame one at a time.
*/
module fsr_host_model
(
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock parked low between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame; rd holds the last eight bits seen, unknown when not driven
  task automatic frame(input logic [39:0] d, input int nb, output logic [7:0] rd);
    #7 cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++)
    begin
      // Bytes past the 40-bit image go out as zero data
      si = (i < 40) ? d[39 - i] : 1'b0;
      #40 sclk = 1'b1;
      rd = {rd[6:0], so_oe ? so_out : 1'bx};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released line flips so a stale bit is never mistaken for data
    si = ~si;
    #200;
  endtask : frame
endmodule : fsr_host_model

// ==== sim/fsr_status_bank_props.sv ====
/*
  Checker for the status bank's system-side ports.
  Assumes it is bound to fsr_status_bank; serial pins are left to the bench.
*/
module fsr_status_bank_props
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Watched ports
  input wire logic [23:0] nv_bits,
  input wire logic nv_store,
  input wire logic op_start,
  input wire logic [7:0] op_code,
  input wire logic target_protected,
  input wire logic [3:0] block_protect,
  input wire logic top_bottom,
  input wire logic quad_enable,
  input wire logic [2:0] security_lock
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Chip wipe has two opcodes
  wire logic chip_op = (op_code == OP_CHIP_WIPE) || (op_code == OP_CHIP_WIPE_ALT);
  a_store_gap: assert property (nv_store |=> !nv_store [*8])
    else $error("status write not held busy");
  a_protect_gate: assert property (op_start && !chip_op |-> !$past(target_protected))
    else $error("protected target started");
  a_chip_gate: assert property (op_start && chip_op |-> block_protect == 4'h0)
    else $error("chip wipe with protect bits set");
  a_guard_hold: assert property (nv_store |-> !$past(nv_bits[B_GUARD_HI]))
    else $error("status write while guarded");
  a_nv_cause: assert property (!$past(reset) && $changed(nv_bits) |-> nv_store)
    else $error("stored bits changed without a write");
  a_protect_slice: assert property (block_protect == nv_bits[B_BP_LO +: 4])
    else $error("protect outputs differ from stored bits");
  a_tb_sticky: assert property (!$past(reset) |-> !$fell(top_bottom))
    else $error("top/bottom select cleared");
  a_lock_sticky: assert property (!$past(reset) |->
    (~security_lock & $past(security_lock)) == 3'h0)
    else $error("lock bit cleared");
  a_quad_on: assert property (quad_enable)
    else $error("quad enable low");
  // Main scenarios reached
  c_store: cover property (nv_store);
  c_start: cover property (op_start && !chip_op);
  c_chip: cover property (op_start && chip_op);
endmodule : fsr_status_bank_props

bind fsr_status_bank fsr_status_bank_props fsr_status_bank_props_i (
  .sys_clk(sys_clk), .reset(reset), .nv_bits(nv_bits), .nv_store(nv_store),
  .op_start(op_start), .op_code(op_code), .target_protected(target_protected),
  .block_protect(block_protect), .top_bottom(top_bottom), .quad_enable(quad_enable),
  .security_lock(security_lock)
);

// ==== sim/testbench.sv ====
/*
  Self-checking bench: scripted status frames, then random programs.
  Assumes the host model and an engine stub stand for the far side.
*/
module testbench
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, reset = 1, target_protected = 0, engine_done = 0, engine_fail = 0;
  logic [1:0] drv;
  logic a4;
  logic sclk, cs_n, si, so_out, so_oe, op_start, susp, resm;
  logic [7:0] ext_addr_hi = 8'h00, op_code, rd;
  logic [23:0] nv_image = 24'h304000;
  logic [31:0] op_addr, seed = 32'h9364;
  logic [63:0] s;
  int n_fail = 0, n_compared = 0, cnt = 0, n_ops = 0, e;
  // Flags, length, frame, read opcode, expected byte
  logic [63:0] steps [31] = '{
    64'h0_0_0000000000_05_00,
    64'h0_0_0000000000_35_03,
    64'h0_0_0000000000_15_30,
    64'h0_1_0600000000_05_02,
    64'h0_1_0400000000_05_00,
    64'h0_2_013c000000_05_00,
    64'h1_2_013f000000_05_3c,
    64'h1_1_6000000000_05_3e,
    64'h1_2_0100000000_05_00,
    64'h5_1_6000000000_05_03,
    64'h0_0_0000000000_05_00,
    64'h3_6_0200000000_15_3c,
    64'h0_1_3000000000_15_30,
    64'h3_5_2000000000_15_38,
    64'h0_1_3000000000_15_30,
    64'h5_6_0201020304_05_03,
    64'h4_1_7500000000_35_07,
    64'h4_1_7a00000000_35_03,
    64'h0_0_0000000000_05_00,
    64'h5_5_2001020304_05_03,
    64'h4_1_7500000000_35_83,
    64'h4_1_6600000000_00_00,
    64'h4_1_9900000000_35_03,
    64'h0_0_0000000000_05_00,
    64'h1_2_1100000000_15_00,
    64'h0_0_0000000000_35_03,
    64'h1_2_3108000000_35_0b,
    64'h1_2_0140000000_05_40,
    64'h1_2_3140000000_35_4b,
    64'h1_2_0144000000_05_42,
    64'h0_1_e900000000_35_4a
  };
  fsr_host_model fsr_host_model_i (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));
  fsr_status_bank fsr_status_bank_i (.sys_clk(sys_clk), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe), .nv_image(nv_image),
    .nv_bits(), .nv_store(), .ext_addr_hi(ext_addr_hi), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .suspend_req(susp), .resume_req(resm),
    .engine_done(engine_done), .engine_fail(engine_fail), .otp_prog_hit(1'b0),
    .otp_erase_hit(1'b0), .block_protect(), .top_bottom(),
    .target_protected(target_protected), .drive_strength(drv), .quad_enable(),
    .security_lock(), .addr_4byte(a4));
  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;
  // Engine stub: long ops so a suspend lands mid-run; negative count is paused
  // A chip wipe by OP_CHIP_WIPE (not OP_CHIP_WIPE_ALT) always ends in failure, to reach the erase error path
  always @(negedge sys_clk)
  begin
    engine_done <= cnt == 1;
    engine_fail <= (cnt == 1) && (op_code == OP_CHIP_WIPE);
    if (op_start)
    begin
      cnt <= 400;
      n_ops <= n_ops + 1;
    end
    else if (susp || resm)
      cnt <= -cnt;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded busy poll; a stuck device shows up in the next compare
  task automatic idle;
    int i = 0;
    do
      fsr_host_model_i.frame({OP_RD_SR1, 32'h0}, 2, rd);
    while (rd[0] !== 1'b0 && ++i < 40);
  endtask : idle
  task automatic test_done;
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Hang guard, well past the expected run
  initial
  begin
    #800us;
    n_fail++;
    test_done();
  end
  // Reset, scripted steps, then random programs in 3-byte mode
  initial
  begin
    repeat (5) @(negedge sys_clk);
    reset = 0;
    repeat (3) @(negedge sys_clk);
    chk(32'(drv), 32'h1);
    chk(32'(a4), 32'h1);
    foreach (steps[k])
    begin
      s = steps[k];
      @(negedge sys_clk);
      target_protected = s[61];
      if (s[60])
        fsr_host_model_i.frame({OP_WRITE_UNLOCK, 32'h0}, 1, rd);
      if (s[59:56] != 4'h0)
        fsr_host_model_i.frame(s[55:16], int'(s[59:56]), rd);
      if (!s[62])
        idle();
      if (s[15:8] != 8'h00)
      begin
        fsr_host_model_i.frame({s[15:8], 32'h0}, 2, rd);
        chk(32'(rd), 32'(s[7:0]));
      end
    end
    e = n_ops;
    for (int j = 0; j < 6; j++)
    begin
      seed = xs(seed);
      @(negedge sys_clk);
      ext_addr_hi = seed[31:24];
      target_protected = seed[0];
      fsr_host_model_i.frame({OP_WRITE_UNLOCK, 32'h0}, 1, rd);
      fsr_host_model_i.frame({OP_PAGE_PGM, seed[23:0], 8'h00}, 5, rd);
      idle();
      e += int'(!seed[0]);
      chk(op_addr, seed);
      chk(n_ops, e);
    end
    chk(32'(drv), 32'h0);
    fsr_host_model_i.frame({OP_ENTER_4B, 32'h0}, 1, rd);
    idle();
    chk(32'(a4), 32'h1);
    test_done();
  end
endmodule : testbench
